/* File: gpc_cfg.svh */
// timing counts, command codes and reset values for the instrument bus controller
`ifndef GPC_CFG_SVH
`define GPC_CFG_SVH
// clock rate in MHz; every timing count below is derived from it
`define GPC_CLK_MHZ 250
`define GPC_US_CYC `GPC_CLK_MHZ
// interface clear pulse, strictly longer than the figure
`define GPC_IFC_US 100
`define GPC_IFC_CYC (`GPC_IFC_US * `GPC_CLK_MHZ + 1)
// data settle time before data valid is asserted
`define GPC_T1_NS 500
`define GPC_T1_CYC ((`GPC_T1_NS * `GPC_CLK_MHZ + 999) / 1000)
// parallel poll response window
`define GPC_PP_NS 2000
`define GPC_PP_CYC ((`GPC_PP_NS * `GPC_CLK_MHZ + 999) / 1000)
// command bytes, bit 7 ignored
`define GPC_LAG_HI 2'h1
`define GPC_TAG_HI 2'h2
`define GPC_CMD_UNL 7'h3F
`define GPC_CMD_UNT 7'h5F
`define GPC_CMD_SPE 7'h18
`define GPC_CMD_SPD 7'h19
`define GPC_CMD_TCT 7'h09
// released bus level, all lines high
`define GPC_BUS_IDLE 16'hFFFF
`define GPC_FIFO_AW 4
`endif

/* File: gpc_pkg.sv */
// types shared by the instrument bus controller
`default_nettype none
package gpc_pkg;
  typedef struct packed {
    logic [7:0] dio;
    logic dav;
    logic nrfd;
    logic ndac;
    logic eoi;
    logic atn;
    logic srq;
    logic ren;
    logic ifc;
  } gpc_lines_t;
  typedef struct packed {
    logic [4:0] my_addr;
    logic sys_ctrl;
    logic talk_only;
    logic listen_only;
    logic ren_set;
    logic rsv;
    logic [15:0] tmo_us;
  } gpc_cfg_t;
  typedef struct packed {
    logic cmd;
    logic last;
    logic two;
    logic [15:0] data;
  } gpc_txw_t;
  typedef struct packed {
    logic last;
    logic two;
    logic [15:0] data;
  } gpc_rxw_t;
  typedef struct packed {
    logic cic;
    logic tadr;
    logic ladr;
    logic spe;
    logic atn;
    logic ren;
    logic ifc_busy;
    logic pp_busy;
    logic srq_now;
    logic srq_fell;
    logic err_nolsn;
    logic err_tmo;
  } gpc_stat_t;
  typedef enum logic [1:0] {SH_IDLE = 2'b00, SH_GNS = 2'b01, SH_DLY = 2'b10, SH_TRS = 2'b11} gpc_sh_t;
  typedef enum logic [1:0] {AH_IDLE = 2'b00, AH_RDY = 2'b01, AH_ACC = 2'b10} gpc_ah_t;
endpackage : gpc_pkg
`default_nettype wire

/* File: gpc_ctrl.sv */
// instrument bus talker, listener and controller with word fifos
// Functional notes
// - interface clear pulse longer than 100 us
// - service request, nrfd and ndac open collector
// - dav, eoi, atn, ren, ifc three-state
// - data lines three-state outside parallel poll
// - data lines open collector during parallel poll
// - host sets remote enable and holds it
// - send any interface message or combination
// - send and detect the end message
// - host reads service request level anytime
// - latch service request true to false
// - serial poll status byte readable per bit
// - flag sourcing byte with no acceptor present
// - host programmable timeout both directions
// - interrupt on service request rising
// - host monitors every bus line
// - fifos pack bytes into sixteen bit words
// - talker unaddressed by own listen address
// - listener unaddressed by own talk address
// - system controller, clear, ren, sync take
// - receive, pass, self pass control, parallel poll
// - interface logic clock rate is configurable
`timescale 1ns/10ps
`default_nettype none
`include "gpc_cfg.svh"

module gpc_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned AW = 4
) (
  // clock
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem [0:(1<<AW)-1];
  logic [AW:0] wp_r;
  logic [AW:0] rp_r;
  logic push;
  logic pop;
  assign in_ready = (wp_r - rp_r) != (AW+1)'(1 << AW);
  assign out_valid = wp_r != rp_r;
  assign out_data = mem[rp_r[AW-1:0]];
  assign push = ce & in_valid & in_ready;
  assign pop = ce & out_valid & out_ready;
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop) rp_r <= rp_r + 1'b1;
    end
  end
endmodule : gpc_fifo

module gpc_ctrl #(
  parameter int unsigned IFC_CYC = `GPC_IFC_CYC,
  parameter int unsigned FIFO_AW = `GPC_FIFO_AW
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  // bus pins, electrical level, low is true
  input wire gpc_pkg::gpc_lines_t bus_i,
  output gpc_pkg::gpc_lines_t bus_o,
  output gpc_pkg::gpc_lines_t bus_oe_n,
  // configuration and host pulses
  input wire gpc_pkg::gpc_cfg_t cfg,
  input wire logic ifc_go,
  input wire logic tcs_go,
  input wire logic pp_go,
  input wire logic srq_fell_clr,
  input wire logic srq_irq_clr,
  input wire logic err_clr,
  // host words toward the bus
  input wire logic tx_valid,
  output logic tx_ready,
  input wire gpc_pkg::gpc_txw_t tx_data,
  // host words from the bus
  output logic rx_valid,
  input wire logic rx_ready,
  output gpc_pkg::gpc_rxw_t rx_data,
  // status
  output gpc_pkg::gpc_stat_t stat,
  output logic [7:0] spoll_byte,
  output logic [7:0] pp_byte,
  output gpc_pkg::gpc_lines_t bus_mon,
  output logic srq_irq
);
  import gpc_pkg::*;
  localparam int unsigned IW = $clog2(IFC_CYC + 1);

  gpc_lines_t bq_r;
  logic b_atn, b_eoi, b_dav, b_nrfd, b_ndac, b_srq, b_ifc;
  logic [7:0] b_dio;
  gpc_sh_t sh_st;
  gpc_ah_t ah_st;
  logic [IW-1:0] ifc_cnt_r;
  logic ifc_on, ifc_d_r;
  logic ren_r, cic_r, atn_r, tadr_r, ladr_r, spe_r;
  logic tadr, ladr, ah_act, sh_idle;
  logic [8:0] pp_cnt_r;
  logic pp_on, dio_oc;
  logic [7:0] sh_byte_r, sh_cnt_r;
  logic sh_eoi_r, sh_cmd_r, sh_sp_r, hi_r;
  logic txq_v, txq_rdy, sh_start, sh_adv, sh_ok, sh_last;
  gpc_txw_t txq;
  logic acc, acc_data, cmd_ev;
  logic [6:0] cmd_c;
  logic pk_have_r;
  logic [7:0] pk_lo_r;
  logic rxp_v, rx_room;
  gpc_rxw_t rxp;
  logic [7:0] us_pre_r;
  logic [15:0] tmo_cnt_r;
  logic waiting, tmo_hit;
  logic srq_prev_r, srq_fell_r, srq_irq_r, err_nolsn_r, err_tmo_r;

  // pins are synchronous; one register stage feeds both logic and monitor
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) bq_r <= `GPC_BUS_IDLE;
    else if (ce) bq_r <= bus_i;
  end
  assign bus_mon = bq_r;
  assign b_atn = ~bq_r.atn;
  assign b_eoi = ~bq_r.eoi;
  assign b_dav = ~bq_r.dav;
  assign b_nrfd = ~bq_r.nrfd;
  assign b_ndac = ~bq_r.ndac;
  assign b_srq = ~bq_r.srq;
  assign b_ifc = ~bq_r.ifc;
  assign b_dio = ~bq_r.dio;
  assign tadr = tadr_r | cfg.talk_only;
  assign ladr = ladr_r | cfg.listen_only;
  assign sh_idle = sh_st == SH_IDLE;

  // interface clear and remote enable, system controller only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ifc_cnt_r <= '0;
      ifc_d_r <= 1'b0;
      ren_r <= 1'b0;
    end else if (ce) begin
      // our own clear comes back one cycle late through the pin register
      ifc_d_r <= ifc_on;
      ren_r <= cfg.sys_ctrl & cfg.ren_set;
      if (ifc_go && cfg.sys_ctrl && !ifc_on) ifc_cnt_r <= IW'(IFC_CYC);
      else if (ifc_on) ifc_cnt_r <= ifc_cnt_r - 1'b1;
    end
  end
  assign ifc_on = ifc_cnt_r != '0;

  // parallel poll: atn and eoi together for a fixed window, then sample
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pp_cnt_r <= '0;
      pp_byte <= 8'h00;
    end else if (ce) begin
      if (pp_go && cic_r && sh_idle && !pp_on) pp_cnt_r <= 9'(`GPC_PP_CYC);
      else if (pp_on) pp_cnt_r <= pp_cnt_r - 1'b1;
      if (pp_cnt_r == 9'h001) pp_byte <= b_dio;
    end
  end
  assign pp_on = pp_cnt_r != '0;
  assign dio_oc = (b_atn & b_eoi) | pp_on;

  // command decode, for bytes we source and bytes we accept alike
  assign cmd_ev = (sh_ok & sh_cmd_r) | (acc & b_atn);
  assign cmd_c = (sh_ok & sh_cmd_r) ? sh_byte_r[6:0] : b_dio[6:0];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tadr_r <= 1'b0;
      ladr_r <= 1'b0;
      spe_r <= 1'b0;
    end else if (ce) begin
      if (b_ifc) begin
        tadr_r <= 1'b0;
        ladr_r <= 1'b0;
        spe_r <= 1'b0;
      end else if (cmd_ev) begin
        if (cmd_c == {`GPC_LAG_HI, cfg.my_addr}) begin
          ladr_r <= 1'b1;
          tadr_r <= 1'b0;
        end else if (cmd_c == {`GPC_TAG_HI, cfg.my_addr}) begin
          tadr_r <= 1'b1;
          ladr_r <= 1'b0;
        end else if (cmd_c[6:5] == `GPC_TAG_HI) begin
          tadr_r <= 1'b0;
        end
        if (cmd_c == `GPC_CMD_UNL) ladr_r <= 1'b0;
        if (cmd_c == `GPC_CMD_SPE) spe_r <= 1'b1;
        if (cmd_c == `GPC_CMD_SPD) spe_r <= 1'b0;
      end
    end
  end

  // controller in charge and attention
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cic_r <= 1'b0;
      atn_r <= 1'b0;
    end else if (ce) begin
      if (ifc_on) begin
        cic_r <= 1'b1;
      end else if (b_ifc && !ifc_d_r) begin
        cic_r <= 1'b0;
        atn_r <= 1'b0;
      end else if (cmd_ev && cmd_c == `GPC_CMD_TCT) begin
        if (tadr) cic_r <= 1'b1;
        else if (sh_cmd_r) begin
          cic_r <= 1'b0;
          atn_r <= 1'b0;
        end
      end else if (!cic_r) begin
        atn_r <= 1'b0;
      end else if (tcs_go && ah_st != AH_ACC) begin
        atn_r <= 1'b1;
      end else if (sh_idle && txq_v && !pp_on) begin
        atn_r <= txq.cmd;
      end
    end
  end

  // source handshake
  gpc_fifo #(.W($bits(gpc_txw_t)), .AW(FIFO_AW)) u_txf (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_data),
    .out_valid(txq_v),
    .out_ready(txq_rdy),
    .out_data(txq)
  );
  assign sh_start = sh_idle && !pp_on && !ifc_on && !b_ifc &&
    ((atn_r && cic_r && txq_v && txq.cmd) ||
     (tadr && !atn_r && !b_atn && (spe_r || (txq_v && !txq.cmd))));
  assign sh_ok = ce && sh_st == SH_TRS && !b_ndac;
  assign sh_adv = ce && !sh_idle && (sh_ok || tmo_hit || (sh_st == SH_GNS && !b_nrfd && !b_ndac));
  assign sh_last = hi_r | ~txq.two;
  assign txq_rdy = sh_adv & ~sh_sp_r & sh_last;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sh_st <= SH_IDLE;
      sh_byte_r <= 8'h00;
      sh_eoi_r <= 1'b0;
      sh_cmd_r <= 1'b0;
      sh_sp_r <= 1'b0;
      sh_cnt_r <= 8'h00;
      hi_r <= 1'b0;
    end else if (ce) begin
      if (sh_adv && !sh_sp_r) hi_r <= ~sh_last;
      unique case (sh_st)
        SH_IDLE: if (sh_start) begin
          sh_cmd_r <= atn_r;
          sh_sp_r <= ~atn_r & spe_r;
          sh_byte_r <= (~atn_r & spe_r) ? {spoll_src_rsv(cfg.rsv), 6'h00} :
                       (hi_r ? txq.data[15:8] : txq.data[7:0]);
          sh_eoi_r <= ~atn_r & ~spe_r & txq.last & (hi_r | ~txq.two);
          sh_st <= SH_GNS;
        end
        SH_GNS: if (sh_adv) sh_st <= SH_IDLE;
          else if (!b_nrfd) begin
            sh_cnt_r <= 8'(`GPC_T1_CYC);
            sh_st <= SH_DLY;
          end
        SH_DLY: if (sh_cnt_r == 8'h01) sh_st <= SH_TRS;
          else sh_cnt_r <= sh_cnt_r - 1'b1;
        SH_TRS: if (sh_adv) sh_st <= SH_IDLE;
      endcase
    end
  end

  function automatic logic [1:0] spoll_src_rsv(input logic rsv);
    spoll_src_rsv = {1'b0, rsv};
  endfunction : spoll_src_rsv

  // acceptor handshake: commands under atn unless we assert it ourselves, data only when listening
  assign ah_act = (b_atn & ~atn_r & ~sh_cmd_r) | (ladr & ~b_atn);
  assign acc = ce && ah_st == AH_RDY && ah_act && b_dav;
  assign acc_data = acc & ~b_atn;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ah_st <= AH_IDLE;
    end else if (ce) begin
      unique case (ah_st)
        AH_IDLE: if (ah_act && (b_atn || rx_room)) ah_st <= AH_RDY;
        AH_RDY: if (!ah_act) ah_st <= AH_IDLE;
          else if (b_dav) ah_st <= AH_ACC;
        AH_ACC: if (!b_dav) ah_st <= AH_IDLE;
        default: ah_st <= AH_IDLE;
      endcase
    end
  end

  // byte to word packing, low byte first; end closes a half word
  assign rxp_v = acc_data & (pk_have_r | b_eoi);
  assign rxp = '{last: b_eoi, two: pk_have_r, data: pk_have_r ? {b_dio, pk_lo_r} : {8'h00, b_dio}};
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pk_have_r <= 1'b0;
      pk_lo_r <= 8'h00;
      spoll_byte <= 8'h00;
    end else if (acc_data) begin
      pk_have_r <= ~pk_have_r & ~b_eoi;
      pk_lo_r <= b_dio;
      if (spe_r && cic_r) spoll_byte <= b_dio;
    end
  end
  gpc_fifo #(.W($bits(gpc_rxw_t)), .AW(FIFO_AW)) u_rxf (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .in_valid(rxp_v),
    .in_ready(rx_room),
    .in_data(rxp),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data)
  );

  // timeout in microseconds; zero disables
  assign waiting = (sh_st == SH_GNS) | (sh_st == SH_TRS) | (ah_st == AH_RDY & ladr & ~b_atn);
  assign tmo_hit = ce && waiting && cfg.tmo_us != 16'h0000 && tmo_cnt_r == cfg.tmo_us;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      us_pre_r <= 8'h00;
      tmo_cnt_r <= 16'h0000;
    end else if (ce) begin
      if (!waiting || tmo_hit) begin
        us_pre_r <= 8'h00;
        tmo_cnt_r <= 16'h0000;
      end else if (us_pre_r == 8'(`GPC_US_CYC - 1)) begin
        us_pre_r <= 8'h00;
        tmo_cnt_r <= tmo_cnt_r + 1'b1;
      end else begin
        us_pre_r <= us_pre_r + 1'b1;
      end
    end
  end

  // sticky flags; a set in the clearing cycle wins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      srq_prev_r <= 1'b0;
      srq_fell_r <= 1'b0;
      srq_irq_r <= 1'b0;
      err_nolsn_r <= 1'b0;
      err_tmo_r <= 1'b0;
    end else if (ce) begin
      srq_prev_r <= b_srq;
      srq_fell_r <= (srq_prev_r & ~b_srq) | (srq_fell_r & ~srq_fell_clr);
      srq_irq_r <= (~srq_prev_r & b_srq) | (srq_irq_r & ~srq_irq_clr);
      err_nolsn_r <= (sh_st == SH_GNS && !b_nrfd && !b_ndac) | (err_nolsn_r & ~err_clr);
      err_tmo_r <= tmo_hit | (err_tmo_r & ~err_clr);
    end
  end
  assign srq_irq = srq_irq_r;
  assign stat = '{cic: cic_r, tadr: tadr, ladr: ladr, spe: spe_r, atn: atn_r | pp_on, ren: ren_r,
                  ifc_busy: ifc_on, pp_busy: pp_on, srq_now: b_srq, srq_fell: srq_fell_r,
                  err_nolsn: err_nolsn_r, err_tmo: err_tmo_r};

  // pin drivers: a true line is driven low
  always_comb begin
    bus_o = `GPC_BUS_IDLE;
    bus_oe_n = `GPC_BUS_IDLE;
    bus_o.srq = 1'b0;
    bus_oe_n.srq = ~(cfg.rsv & ~cic_r);
    bus_o.nrfd = 1'b0;
    bus_oe_n.nrfd = ~(ah_act & (ah_st != AH_RDY));
    bus_o.ndac = 1'b0;
    bus_oe_n.ndac = ~(ah_act & (ah_st != AH_ACC));
    bus_oe_n.dav = sh_idle;
    bus_o.dav = ~(sh_st == SH_TRS);
    bus_oe_n.eoi = sh_idle & ~pp_on;
    bus_o.eoi = ~(pp_on | (sh_eoi_r & (sh_st == SH_DLY || sh_st == SH_TRS)));
    bus_oe_n.atn = ~cic_r;
    bus_o.atn = ~(atn_r | pp_on);
    bus_oe_n.ren = ~cfg.sys_ctrl;
    bus_o.ren = ~ren_r;
    bus_oe_n.ifc = ~cfg.sys_ctrl;
    bus_o.ifc = ~ifc_on;
    if (!sh_idle) begin
      if (dio_oc) begin
        bus_o.dio = 8'h00;
        bus_oe_n.dio = ~sh_byte_r;
      end else begin
        bus_o.dio = ~sh_byte_r;
        bus_oe_n.dio = 8'h00;
      end
    end
  end

  // checks
  int unsigned ifc_len_r;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) ifc_len_r <= 0;
    else ifc_len_r <= ifc_on ? ifc_len_r + 1 : 0;
  end
  AST_IFC_LEN: assert property (@(posedge clk) disable iff (!arst_n) $fell(ifc_on) |-> ifc_len_r >= IFC_CYC)
    else $error("ifc pulse too short");
  AST_OC_ONLY: assert property (@(posedge clk) disable iff (!arst_n)
    (!bus_oe_n.srq || !bus_oe_n.nrfd || !bus_oe_n.ndac) |-> (!bus_o.srq && !bus_o.nrfd && !bus_o.ndac))
    else $error("open collector line driven high");
  AST_DIO_TRI: assert property (@(posedge clk) disable iff (!arst_n) (!sh_idle && !dio_oc) |-> bus_oe_n.dio == 8'h00)
    else $error("data lines not three-state");
  AST_DIO_OC: assert property (@(posedge clk) disable iff (!arst_n) (!sh_idle && b_atn && b_eoi) |-> bus_o.dio == 8'h00)
    else $error("data lines driven high in poll");
  AST_REN_SET: assert property (@(posedge clk) disable iff (!arst_n)
    (ce && cfg.sys_ctrl && cfg.ren_set) |=> (!bus_o.ren && !bus_oe_n.ren))
    else $error("ren not asserted");
  AST_SRQ_FELL: assert property (@(posedge clk) disable iff (!arst_n) (ce && srq_prev_r && !b_srq) |=> stat.srq_fell)
    else $error("srq fall not latched");
  AST_SRQ_IRQ: assert property (@(posedge clk) disable iff (!arst_n) (ce && !srq_prev_r && b_srq) |=> srq_irq)
    else $error("srq rise gave no irq");
  AST_NOLSN: assert property (@(posedge clk) disable iff (!arst_n)
    (ce && sh_st == SH_GNS && !b_nrfd && !b_ndac) |=> (stat.err_nolsn && sh_st == SH_IDLE))
    else $error("no-acceptor error missed");
  AST_MLA_UNT: assert property (@(posedge clk) disable iff (!arst_n)
    (ce && cmd_ev && !b_ifc && cmd_c == {`GPC_LAG_HI, cfg.my_addr}) |=> !tadr_r)
    else $error("talker kept address");
  AST_EOI_LAST: assert property (@(posedge clk) disable iff (!arst_n) (sh_st == SH_TRS && sh_eoi_r) |-> !bus_o.eoi)
    else $error("eoi missing with last byte");
  COV_IFC: cover property (@(posedge clk) disable iff (!arst_n) $fell(ifc_on));
  COV_CMD: cover property (@(posedge clk) disable iff (!arst_n) sh_ok && sh_cmd_r);
  COV_PP: cover property (@(posedge clk) disable iff (!arst_n) pp_cnt_r == 9'h001);
  COV_RX_END: cover property (@(posedge clk) disable iff (!arst_n) rxp_v && rx_room && b_eoi);
endmodule : gpc_ctrl
`default_nettype wire

/* File: gpc_instr.sv */
// behavioural instrument on the far side of the cable: acceptor, source, poll responder
`timescale 1ns/10ps
`default_nettype none
module gpc_instr (
  // clock and cable level
  input wire logic clk,
  input wire gpc_pkg::gpc_lines_t bus,
  // own drivers, enable low, open collector only
  output gpc_pkg::gpc_lines_t drv,
  output gpc_pkg::gpc_lines_t drv_oe_n,
  // behaviour chosen by the bench
  input wire logic listen,
  input wire logic stall,
  input wire logic srq_req,
  input wire logic [7:0] pp_resp
);
  import gpc_pkg::*;
  logic [9:0] got[$];
  logic ah_acc, nrfd_a, ndac_a, src_dav, src_eoi;
  logic [7:0] src_dio;
  wire logic pp_on = !bus.atn && !bus.eoi;

  initial begin
    ah_acc = 1'b0;
    nrfd_a = 1'b0;
    ndac_a = 1'b0;
    src_dav = 1'b0;
    src_eoi = 1'b0;
    src_dio = 8'hFF;
  end

  // only ever pulls low, so a released line shows the pull-up level and never a stale value
  assign drv = '0;
  always_comb begin
    drv_oe_n = '1;
    drv_oe_n.dio = src_dio & (pp_on ? ~pp_resp : 8'hFF);
    drv_oe_n.dav = ~src_dav;
    drv_oe_n.eoi = ~src_eoi;
    drv_oe_n.nrfd = ~nrfd_a;
    drv_oe_n.ndac = ~ndac_a;
    drv_oe_n.srq = ~srq_req;
  end

  // acceptor: stall holds ndac asserted, the only way this model misbehaves
  always @(posedge clk) begin
    if (!listen) begin
      ah_acc <= 1'b0;
      nrfd_a <= 1'b0;
      ndac_a <= 1'b0;
    end else if (!ah_acc) begin
      ndac_a <= 1'b1;
      nrfd_a <= 1'b0;
      if (!bus.dav && ndac_a) begin
        got.push_back({~bus.atn, ~bus.eoi, ~bus.dio});
        nrfd_a <= 1'b1;
        ah_acc <= 1'b1;
      end
    end else if (bus.dav) begin
      ndac_a <= 1'b1;
      ah_acc <= 1'b0;
    end else begin
      ndac_a <= stall;
    end
  end

  task automatic talk(input logic [7:0] b, input logic last);
    int n;
    @(posedge clk);
    src_dio <= ~b;
    src_eoi <= last;
    for (n = 0; n < 400 && bus.nrfd !== 1'b1; n++) @(posedge clk);
    repeat (2) @(posedge clk);
    src_dav <= 1'b1;
    for (n = 0; n < 400 && bus.ndac !== 1'b1; n++) @(posedge clk);
    src_dav <= 1'b0;
    src_eoi <= 1'b0;
    src_dio <= 8'hFF;
  endtask : talk
endmodule : gpc_instr
`default_nettype wire

/* File: gpc_tb.sv */
// self-checking bench for the instrument bus controller
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import gpc_pkg::*;
  localparam int unsigned IFC_P = 40;
  logic clk, arst_n, ifc_go, pp_go, srq_fell_clr, srq_irq_clr, err_clr, tx_valid, rx_ready, ce, tcs_go;
  logic listen, stall, srq_req, tx_ready, rx_valid, srq_irq, oc_bad, dio_bad;
  logic [7:0] pp_resp, spoll_byte, pp_byte;
  gpc_cfg_t cfg;
  gpc_txw_t tx_data;
  gpc_rxw_t rx_data;
  gpc_stat_t stat;
  gpc_lines_t bus_o, bus_oe_n, bus_mon, p_o, p_oe_n, cable;
  int err_total, samples_checked;

  // wired-and of both parties, pull-ups make released lines high
  assign cable = (bus_o | bus_oe_n) & (p_o | p_oe_n);

  gpc_ctrl #(.IFC_CYC(IFC_P), .FIFO_AW(4)) DUT (
    .clk(clk), .arst_n(arst_n), .ce(ce), .bus_i(cable), .bus_o(bus_o), .bus_oe_n(bus_oe_n), .cfg(cfg),
    .ifc_go(ifc_go), .tcs_go(tcs_go), .pp_go(pp_go), .srq_fell_clr(srq_fell_clr), .srq_irq_clr(srq_irq_clr),
    .err_clr(err_clr), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_data(rx_data), .stat(stat), .spoll_byte(spoll_byte), .pp_byte(pp_byte),
    .bus_mon(bus_mon), .srq_irq(srq_irq));

  gpc_instr u_inst (.clk(clk), .bus(cable), .drv(p_o), .drv_oe_n(p_oe_n), .listen(listen), .stall(stall),
    .srq_req(srq_req), .pp_resp(pp_resp));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // driver discipline watched on every edge, judged at the end of the poll scenario
  always @(posedge clk) begin
    if ((!bus_oe_n.srq && bus_o.srq) || (!bus_oe_n.nrfd && bus_o.nrfd) || (!bus_oe_n.ndac && bus_o.ndac))
      oc_bad <= 1'b1;
    if (stat.pp_busy ? |(~bus_oe_n.dio & bus_o.dio) : (!bus_oe_n.dav && !bus_o.dav && bus_oe_n.dio !== 8'h00))
      dio_bad <= 1'b1;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  // holds valid across words so back-to-back pushes never lower and raise it in one step
  task automatic send(input gpc_txw_t w[$]);
    foreach (w[i]) begin
      @(posedge clk);
      tx_valid <= 1'b1;
      tx_data <= w[i];
    end
    @(posedge clk);
    tx_valid <= 1'b0;
  endtask : send

  task automatic clr_err;
    @(posedge clk);
    err_clr <= 1'b1;
    @(posedge clk);
    err_clr <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : clr_err

  task automatic t_reset;
    check("oe_n", bus_oe_n, 16'hFFFC);
    check("mon", bus_mon, 16'hFFFF);
    check("stat", stat, 12'h000);
    check("fifo irq bytes", {tx_ready, rx_valid, srq_irq, spoll_byte, pp_byte}, 19'h40000);
  endtask : t_reset

  task automatic t_ifc;
    int n;
    n = 0;
    @(posedge clk);
    ifc_go <= 1'b1;
    @(posedge clk);
    ifc_go <= 1'b0;
    repeat (IFC_P + 20) begin
      @(posedge clk);
      if (!cable.ifc) n++;
    end
    #1;
    check("ifc cycles", n, IFC_P);
    check("cic", stat.cic, 1'b1);
    check("ifc owned", {bus_oe_n.ifc, bus_o.ifc}, 2'b01);
  endtask : t_ifc

  task automatic t_ren;
    @(posedge clk);
    ce <= 1'b0;
    cfg.ren_set <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check("ren frozen", stat.ren, 1'b0);
    @(posedge clk);
    ce <= 1'b1;
    repeat (20) @(posedge clk);
    #1;
    check("ren on", {cable.ren, stat.ren, bus_oe_n.ren}, 3'b010);
    cfg.ren_set <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    check("ren off", {cable.ren, stat.ren, bus_oe_n.ren}, 3'b100);
  endtask : t_ren

  task automatic t_srq;
    @(posedge clk);
    srq_req <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check("srq on", {stat.srq_now, bus_mon.srq, srq_irq, stat.srq_fell}, 4'b1010);
    @(posedge clk);
    srq_irq_clr <= 1'b1;
    srq_req <= 1'b0;
    @(posedge clk);
    srq_irq_clr <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    check("srq fell", {stat.srq_now, srq_irq, stat.srq_fell}, 3'b001);
    @(posedge clk);
    srq_fell_clr <= 1'b1;
    @(posedge clk);
    srq_fell_clr <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check("srq cleared", stat.srq_fell, 1'b0);
  endtask : t_srq

  task automatic t_tx;
    int n;
    logic [9:0] exp_b[4] = '{10'h23F, 10'h05A, 10'h1A5, 10'h03C};
    @(posedge clk);
    cfg.talk_only <= 1'b1;
    listen <= 1'b1;
    send('{'{1'b1, 1'b0, 1'b0, 16'h003F}, '{1'b0, 1'b1, 1'b1, 16'hA55A}, '{1'b0, 1'b0, 1'b0, 16'h003C}});
    for (n = 0; n < 2000 && u_inst.got.size() < 4; n++) @(posedge clk);
    repeat (10) @(posedge clk);
    check("byte count", u_inst.got.size(), 4);
    foreach (exp_b[i]) check("byte", u_inst.got[i], exp_b[i]);
    listen <= 1'b0;
    u_inst.got.delete();
  endtask : t_tx

  task automatic t_rx;
    @(posedge clk);
    cfg.talk_only <= 1'b0;
    cfg.listen_only <= 1'b1;
    u_inst.talk(8'h12, 1'b0);
    u_inst.talk(8'h34, 1'b1);
    u_inst.talk(8'h77, 1'b1);
    repeat (4) @(posedge clk);
    #1;
    check("rx word", {rx_valid, rx_data}, {3'b111, 16'h3412});
    @(posedge clk);
    rx_ready <= 1'b1;
    @(posedge clk);
    rx_ready <= 1'b0;
    #1;
    check("rx end", {rx_valid, rx_data.last, rx_data.two, rx_data.data[7:0]}, {3'b110, 8'h77});
    @(posedge clk);
    rx_ready <= 1'b1;
    @(posedge clk);
    rx_ready <= 1'b0;
    #1;
    check("rx empty", rx_valid, 1'b0);
  endtask : t_rx

  task automatic t_nolsn;
    int n;
    @(posedge clk);
    cfg.listen_only <= 1'b0;
    cfg.talk_only <= 1'b1;
    send('{'{1'b0, 1'b0, 1'b0, 16'h0055}});
    for (n = 0; n < 300 && stat.err_nolsn !== 1'b1; n++) @(posedge clk);
    #1;
    check("no acceptor", {stat.err_nolsn, stat.err_tmo}, 2'b10);
    clr_err;
    check("no acceptor clr", stat.err_nolsn, 1'b0);
  endtask : t_nolsn

  task automatic t_tmo;
    int n;
    @(posedge clk);
    cfg.tmo_us <= 16'h0002;
    listen <= 1'b1;
    stall <= 1'b1;
    send('{'{1'b0, 1'b0, 1'b0, 16'h0066}});
    for (n = 0; n < 1000 && stat.err_tmo !== 1'b1; n++) @(posedge clk);
    #1;
    check("tmo span", (n >= 350 && n < 800), 1'b1);
    check("tmo flag", stat.err_tmo, 1'b1);
    stall <= 1'b0;
    listen <= 1'b0;
    cfg.tmo_us <= 16'h0000;
    clr_err;
    check("tmo clr", stat.err_tmo, 1'b0);
    u_inst.got.delete();
  endtask : t_tmo

  task automatic t_pp;
    int n;
    n = 0;
    @(posedge clk);
    cfg.talk_only <= 1'b0;
    pp_resp <= 8'h21;
    pp_go <= 1'b1;
    @(posedge clk);
    pp_go <= 1'b0;
    repeat (600) begin
      @(posedge clk);
      if (!cable.eoi) n++;
    end
    #1;
    check("poll span", n, 500);
    check("poll byte", pp_byte, 8'h21);
    check("drivers", {oc_bad, dio_bad}, 2'b00);
    @(posedge clk);
    tcs_go <= 1'b1;
    @(posedge clk);
    tcs_go <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check("take sync", {stat.atn, cable.atn}, 2'b10);
  endtask : t_pp

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    final_report();
  end

  initial begin
    arst_n = 1'b0;
    ifc_go = 1'b0;
    ce = 1'b1;
    tcs_go = 1'b0;
    pp_go = 1'b0;
    srq_fell_clr = 1'b0;
    srq_irq_clr = 1'b0;
    err_clr = 1'b0;
    tx_valid = 1'b0;
    rx_ready = 1'b0;
    tx_data = '0;
    cfg = '{5'h03, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0000};
    listen = 1'b0;
    stall = 1'b0;
    srq_req = 1'b0;
    pp_resp = 8'h00;
    oc_bad = 1'b0;
    dio_bad = 1'b0;
    err_total = 0;
    samples_checked = 0;
    repeat (12) @(posedge clk);
    t_reset();
    arst_n <= 1'b1;
    t_ifc();
    t_ren();
    t_srq();
    t_tx();
    t_rx();
    t_nolsn();
    t_tmo();
    t_pp();
    final_report();
  end
endmodule : testbench
`default_nettype wire
